// *** rtl/tws_master.sv ***
// Two-wire serial bus master: transmit and receive state handling.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps

module tws_master
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire tws_pkg::tws_line_t pin_in,
  output tws_pkg::tws_line_t pin_out,
  output tws_pkg::tws_line_t pin_oe_b
);

  tws_pkg::tws_state_t state_r;
  tws_pkg::tws_state_t state_nxt;
  tws_pkg::tws_ctrl_t ctrl_r;
  tws_pkg::tws_ctrl_t ctrl_nxt;
  tws_pkg::tws_line_t meta_r;
  tws_pkg::tws_line_t line_r;
  tws_pkg::tws_line_t line_d_r;
  tws_pkg::tws_line_t oe_b_nxt;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] data_r;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [8:0] qcnt_r;
  logic [8:0] qcnt_nxt;
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic [3:0] bit_r;
  logic [3:0] bit_nxt;
  logic busy_r;
  logic lost_r;
  logic lost_nxt;
  logic rep_r;
  logic rep_nxt;
  logic addr_phase_r;
  logic addr_phase_nxt;
  logic rx_mode_r;
  logic rx_mode_nxt;
  logic ack_out_r;
  logic ack_out_nxt;
  logic pend_r;
  logic pend_nxt;
  logic flag_set;
  logic stop_done;
  logic rx_load;
  logic scl_low;
  logic sda_low;

  // Register port decode.
  wire tws_pkg::tws_ctrl_t ctrl_w = tws_pkg::tws_ctrl_t'(reg_wdata);
  wire wr_ctrl = reg_wr && (reg_addr == tws_pkg::OFS_CONTROL);
  wire wr_data = reg_wr && (reg_addr == tws_pkg::OFS_DATA);
  wire clear_req = wr_ctrl && ctrl_w.step_done_flag;
  // The enable as it stands after this cycle, so that a single write that
  // enables the interface and requests a START is not thrown away.
  wire enable_nxt = wr_ctrl ? ctrl_w.interface_enable :
                    ctrl_r.interface_enable;
  wire data_ok = wr_data && ctrl_r.step_done_flag;
  wire data_coll = wr_data && !ctrl_r.step_done_flag;
  wire [7:0] status_rd = status_r & tws_pkg::STATUS_CODE_MASK;
  wire [7:0] rd_val = (reg_addr == tws_pkg::OFS_CONTROL) ? ctrl_r :
                      (reg_addr == tws_pkg::OFS_STATUS) ? status_rd :
                      (reg_addr == tws_pkg::OFS_DATA) ? data_r : 8'h00;

  // Bus observation on the synchronised wires.
  wire scl_high = line_r.scl;
  wire sda_in = line_r.sda;
  wire bus_start = line_d_r.scl && scl_high && line_d_r.sda && !sda_in;
  wire bus_stop = line_d_r.scl && scl_high && !line_d_r.sda && sda_in;

  // Quarter-period sequencer.  Phase 2 waits for the clock wire to rise
  // so that a slave stretching the clock is honoured.
  wire run = (state_r == tws_pkg::TWS_START) ||
             (state_r == tws_pkg::TWS_BYTE) ||
             (state_r == tws_pkg::TWS_STOP);
  wire stretch = (phase_r == 2'h2) && !scl_high;
  wire step = run && !stretch && (qcnt_r == tws_pkg::QUARTER_CYC - 9'h001);
  wire last_phase = step && (phase_r == 2'h3);

  // Level for the current bit and the arbitration check on it.
  wire ack_bit = (bit_r == tws_pkg::ACK_BIT);
  wire txing = addr_phase_r || !rx_mode_r;
  wire sda_level = txing ? (ack_bit || shift_r[7]) :
                   (!ack_bit || !ack_out_r);
  wire we_drive = txing ? !ack_bit : ack_bit;
  wire lost_now = (state_r == tws_pkg::TWS_BYTE) && last_phase &&
                  we_drive && sda_level && !sda_in;
  wire ack_seen = !sda_in;

  // Outcome code of a transmitted byte.
  wire [7:0] tx_code =
    !addr_phase_r ?
      (ack_seen ? tws_pkg::SC_MT_DATA_ACK : tws_pkg::SC_MT_DATA_NACK) :
    rx_mode_r ?
      (ack_seen ? tws_pkg::SC_MR_ADDR_ACK : tws_pkg::SC_MR_ADDR_NACK) :
      (ack_seen ? tws_pkg::SC_MT_ADDR_ACK : tws_pkg::SC_MT_ADDR_NACK);
  wire [7:0] rx_code =
    ack_out_r ? tws_pkg::SC_MR_DATA_ACK : tws_pkg::SC_MR_DATA_NACK;

  // Status codes held in the wait state, grouped by what may follow.
  wire in_addr_step = (status_r == tws_pkg::SC_START) ||
                      (status_r == tws_pkg::SC_RESTART);
  wire in_rx_step = (status_r == tws_pkg::SC_MR_ADDR_ACK) ||
                    (status_r == tws_pkg::SC_MR_DATA_ACK);
  wire in_end_step = (status_r == tws_pkg::SC_MR_ADDR_NACK) ||
                     (status_r == tws_pkg::SC_MR_DATA_NACK);

  always_comb
  begin
    state_nxt = state_r;
    phase_nxt = step ? phase_r + 2'h1 : phase_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    status_nxt = status_r;
    lost_nxt = lost_r;
    rep_nxt = rep_r;
    addr_phase_nxt = addr_phase_r;
    rx_mode_nxt = rx_mode_r;
    ack_out_nxt = ack_out_r;
    pend_nxt = pend_r;
    flag_set = 1'b0;
    stop_done = 1'b0;
    rx_load = 1'b0;
    case (state_r)
      tws_pkg::TWS_IDLE:
      begin
        if (clear_req && ctrl_w.start_request && ctrl_w.interface_enable)
          pend_nxt = 1'b1;
        if (pend_r && !busy_r)
        begin
          state_nxt = tws_pkg::TWS_START;
          rep_nxt = 1'b0;
          pend_nxt = 1'b0;
        end
      end
      tws_pkg::TWS_START:
      begin
        if (last_phase)
        begin
          state_nxt = tws_pkg::TWS_HOLD;
          flag_set = 1'b1;
          status_nxt = rep_r ? tws_pkg::SC_RESTART :
                       tws_pkg::SC_START;
        end
      end
      tws_pkg::TWS_BYTE:
      begin
        if (lost_now)
        begin
          state_nxt = tws_pkg::TWS_HOLD;
          lost_nxt = 1'b1;
          flag_set = 1'b1;
          status_nxt = tws_pkg::SC_ARB_LOST;
        end
        else if (last_phase && ack_bit)
        begin
          state_nxt = tws_pkg::TWS_HOLD;
          flag_set = 1'b1;
          rx_load = !txing;
          status_nxt = txing ? tx_code : rx_code;
        end
        else if (last_phase)
        begin
          bit_nxt = bit_r + 4'h1;
          shift_nxt = {shift_r[6:0], sda_in};
        end
      end
      tws_pkg::TWS_HOLD:
      begin
        // A refused step drops the flag for one cycle, so software sees
        // its clear taken, then raises it again on the same status.
        if (!ctrl_r.step_done_flag)
          flag_set = 1'b1;
        if (clear_req)
        begin
          if (lost_r)
          begin
            state_nxt = tws_pkg::TWS_IDLE;
            pend_nxt = ctrl_w.start_request;
            lost_nxt = 1'b0;
            status_nxt = tws_pkg::SC_IDLE;
          end
          else if (ctrl_w.stop_request)
          begin
            state_nxt = tws_pkg::TWS_STOP;
            pend_nxt = ctrl_w.start_request;
          end
          else if (ctrl_w.start_request)
          begin
            state_nxt = tws_pkg::TWS_START;
            rep_nxt = 1'b1;
          end
          else if (in_end_step)
            state_nxt = tws_pkg::TWS_HOLD;
          else if (in_rx_step)
          begin
            state_nxt = tws_pkg::TWS_BYTE;
            bit_nxt = 4'h0;
            addr_phase_nxt = 1'b0;
            ack_out_nxt = ctrl_w.ack_enable;
          end
          else
          begin
            state_nxt = tws_pkg::TWS_BYTE;
            bit_nxt = 4'h0;
            shift_nxt = data_r;
            addr_phase_nxt = in_addr_step;
            rx_mode_nxt = in_addr_step ? data_r[0] :
                          rx_mode_r;
          end
        end
      end
      tws_pkg::TWS_STOP:
      begin
        if (last_phase)
        begin
          state_nxt = tws_pkg::TWS_IDLE;
          stop_done = 1'b1;
          status_nxt = tws_pkg::SC_IDLE;
        end
      end
      default:
        state_nxt = tws_pkg::TWS_IDLE;
    endcase
    // Disabling the interface abandons any transfer and frees the wires.
    if (!enable_nxt)
    begin
      state_nxt = tws_pkg::TWS_IDLE;
      phase_nxt = 2'h0;
      pend_nxt = 1'b0;
      lost_nxt = 1'b0;
    end
  end

  // Control register: the hardware set of the flag wins over a clear
  // arriving in the same cycle, so no completed step is ever lost.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
    begin
      ctrl_nxt.ack_enable = ctrl_w.ack_enable;
      ctrl_nxt.start_request = ctrl_w.start_request;
      ctrl_nxt.stop_request = ctrl_w.stop_request;
      ctrl_nxt.interface_enable = ctrl_w.interface_enable;
      ctrl_nxt.interrupt_enable = ctrl_w.interrupt_enable;
    end
    else if (stop_done)
      ctrl_nxt.stop_request = 1'b0;
    ctrl_nxt.reserved = 1'b0;
    if (flag_set)
      ctrl_nxt.step_done_flag = 1'b1;
    else if (clear_req)
      ctrl_nxt.step_done_flag = 1'b0;
    if (data_coll)
      ctrl_nxt.write_collision = 1'b1;
    else if (data_ok)
      ctrl_nxt.write_collision = 1'b0;
  end

  // Wire drive.  Within a byte the data wire only changes in phase 1, a quarter after
  // the clock wire fell, so a data edge never meets a high clock and
  // fakes a START or STOP.  In the wait state the clock is held low unless arbitration was lost.
  always_comb
  begin
    scl_low = 1'b0;
    sda_low = !pin_oe_b.sda;
    case (state_r)
      tws_pkg::TWS_IDLE:
        sda_low = 1'b0;
      tws_pkg::TWS_START:
      begin
        scl_low = rep_r && (phase_r < 2'h2);
        sda_low = (phase_r == 2'h3);
      end
      tws_pkg::TWS_BYTE:
      begin
        scl_low = (phase_r < 2'h2);
        if (phase_r != 2'h0)
          sda_low = !sda_level;
      end
      tws_pkg::TWS_HOLD:
      begin
        scl_low = !lost_r;
        if (lost_r)
          sda_low = 1'b0;
      end
      tws_pkg::TWS_STOP:
      begin
        scl_low = (phase_r < 2'h2);
        if (phase_r != 2'h0)
          sda_low = (phase_r != 2'h3);
      end
      default:
        sda_low = 1'b0;
    endcase
    oe_b_nxt.scl = !(scl_low && ctrl_r.interface_enable);
    oe_b_nxt.sda = !(sda_low && ctrl_r.interface_enable);
  end

  always_comb
  begin
    qcnt_nxt = qcnt_r + 9'h001;
    if (!run || stretch || step)
      qcnt_nxt = 9'h000;
  end

  // Two-stage synchroniser on the wires, then one more stage for edges.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= 2'b11;
      line_r <= 2'b11;
      line_d_r <= 2'b11;
      busy_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin_in;
      line_r <= meta_r;
      line_d_r <= line_r;
      busy_r <= bus_start || (busy_r && !bus_stop);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= tws_pkg::TWS_IDLE;
      phase_r <= 2'h0;
      qcnt_r <= 9'h000;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      status_r <= tws_pkg::SC_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      qcnt_r <= qcnt_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lost_r <= 1'b0;
      rep_r <= 1'b0;
      addr_phase_r <= 1'b0;
      rx_mode_r <= 1'b0;
      ack_out_r <= 1'b0;
      pend_r <= 1'b0;
    end
    else
    begin
      lost_r <= lost_nxt;
      rep_r <= rep_nxt;
      addr_phase_r <= addr_phase_nxt;
      rx_mode_r <= rx_mode_nxt;
      ack_out_r <= ack_out_nxt;
      pend_r <= pend_nxt;
    end
  end

  // Software loads and received bytes can never collide: loads are only
  // taken while the flag is set, bytes only arrive while it is clear.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      data_r <= tws_pkg::DATA_RESET;
    else if (rx_load)
      data_r <= shift_r;
    else if (data_ok)
      data_r <= reg_wdata;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r <= tws_pkg::CONTROL_RESET;
      reg_rdata <= 8'h00;
      irq <= 1'b0;
      pin_out <= 2'b00;
      pin_oe_b <= 2'b11;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      reg_rdata <= reg_rd ? rd_val : 8'h00;
      irq <= ctrl_nxt.step_done_flag && ctrl_nxt.interrupt_enable &&
             ctrl_nxt.interface_enable;
      pin_out <= 2'b00;
      pin_oe_b <= oe_b_nxt;
    end
  end

endmodule : tws_master

// *** rtl/tws_pkg.sv ***
// Shared constants and types for the two-wire serial master block.
package tws_pkg;

  // Register indices on the plain register port.
  localparam logic [1:0] OFS_CONTROL = 2'h0;
  localparam logic [1:0] OFS_STATUS = 2'h1;
  localparam logic [1:0] OFS_DATA = 2'h2;

  // Control register layout, most significant bit first.
  typedef struct packed {
    logic step_done_flag;
    logic ack_enable;
    logic start_request;
    logic stop_request;
    logic write_collision;
    logic interface_enable;
    logic reserved;
    logic interrupt_enable;
  } tws_ctrl_t;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hff;

  // Status codes; the low three bits are unused and read as zero.
  localparam logic [7:0] STATUS_CODE_MASK = 8'hf8;
  localparam logic [7:0] SC_START = 8'h08;
  localparam logic [7:0] SC_RESTART = 8'h10;
  localparam logic [7:0] SC_MT_ADDR_ACK = 8'h18;
  localparam logic [7:0] SC_MT_ADDR_NACK = 8'h20;
  localparam logic [7:0] SC_MT_DATA_ACK = 8'h28;
  localparam logic [7:0] SC_MT_DATA_NACK = 8'h30;
  localparam logic [7:0] SC_ARB_LOST = 8'h38;
  localparam logic [7:0] SC_MR_ADDR_ACK = 8'h40;
  localparam logic [7:0] SC_MR_ADDR_NACK = 8'h48;
  localparam logic [7:0] SC_MR_DATA_ACK = 8'h50;
  localparam logic [7:0] SC_MR_DATA_NACK = 8'h58;
  localparam logic [7:0] SC_IDLE = 8'hf8;

  // Bus timing: each bit is four quarter periods of the serial clock.
  localparam int CLK_PERIOD_NS = 10;
  localparam int QUARTER_NS = 2500;
  localparam logic [8:0] QUARTER_CYC =
    9'((QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] ACK_BIT = 4'h8;

  // One bit for each wire of the bus.
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_line_t;

  typedef enum logic [4:0] {
    TWS_IDLE = 5'b00001,
    TWS_START = 5'b00010,
    TWS_BYTE = 5'b00100,
    TWS_HOLD = 5'b01000,
    TWS_STOP = 5'b10000
  } tws_state_t;

endpackage : tws_pkg

// *** tb/tb_tws_master.sv ***
// Self-checking bench for the two-wire serial master.
`timescale 1ns/10ps

module tb_tws_master;
  localparam logic [7:0] TXF = 8'hc3;
  localparam logic [1:0] CT = tws_pkg::OFS_CONTROL;
  localparam logic [1:0] ST = tws_pkg::OFS_STATUS;
  localparam logic [1:0] DT = tws_pkg::OFS_DATA;
  logic clk;
  logic rst_b;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic irq;
  tws_pkg::tws_line_t pin_in;
  tws_pkg::tws_line_t pin_out;
  tws_pkg::tws_line_t pin_oe_b;
  logic slv_oe_b;
  logic slv_ack;
  logic [7:0] rx_byte;
  int miscompares;
  int n_checks;

  // Pulled-up open-drain wires: any party pulling low wins.
  assign pin_in = {pin_oe_b.scl, pin_oe_b.sda & slv_oe_b};

  tws_master dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_b(pin_oe_b));

  tws_slave_model #(.TX_FIRST(TXF)) slv_u (.scl(pin_in.scl),
    .sda(pin_in.sda), .ack_data(slv_ack), .sda_oe_b(slv_oe_b),
    .rx_byte(rx_byte));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude;
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [1:0] a, input logic [7:0] e,
    input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask : rdc

  // One software step: write control, wait for the flag, check status.
  task automatic step(input logic [7:0] c, input logic [7:0] s,
    input string nm);
    int i;
    wr(CT, c);
    i = 0;
    repeat (2) @(posedge clk);
    #1;
    while (irq !== 1'b1 && i < 12000)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    rdc(ST, s, nm);
  endtask : step

  task automatic t_regs;
    rdc(CT, tws_pkg::CONTROL_RESET, "control");
    rdc(ST, tws_pkg::SC_IDLE, "status");
    rdc(DT, tws_pkg::DATA_RESET, "data");
    rdc(2'h3, 8'h00, "unmapped");
    wr(CT, 8'h05);
    wr(DT, 8'h3c);
    rdc(CT, 8'h0d, "collision");
    rdc(DT, tws_pkg::DATA_RESET, "discarded");
  endtask : t_regs

  task automatic t_write;
    step(8'ha5, tws_pkg::SC_START, "start");
    chk("scl held", 8'h00, {7'h0, pin_oe_b.scl});
    wr(DT, 8'ha0);
    rdc(CT, 8'ha5, "collision cleared");
    step(8'h85, tws_pkg::SC_MT_ADDR_ACK, "write addr");
    wr(DT, 8'h5a);
    slv_ack <= 1'b1;
    step(8'h85, tws_pkg::SC_MT_DATA_ACK, "data ack");
    chk("slave byte", 8'h5a, rx_byte);
    slv_ack <= 1'b0;
    wr(DT, 8'h69);
    step(8'h85, tws_pkg::SC_MT_DATA_NACK, "data nack");
    chk("slave byte 2", 8'h69, rx_byte);
  endtask : t_write

  task automatic t_read;
    step(8'ha5, tws_pkg::SC_RESTART, "restart");
    wr(DT, 8'ha1);
    step(8'h85, tws_pkg::SC_MR_ADDR_ACK, "read addr");
    step(8'hc5, tws_pkg::SC_MR_DATA_ACK, "rx ack");
    rdc(DT, TXF, "rx byte 1");
    step(8'h85, tws_pkg::SC_MR_DATA_NACK, "rx nack");
    rdc(DT, TXF + 8'h01, "rx byte 2");
    rdc(DT, TXF + 8'h01, "rx held");
    step(8'h85, tws_pkg::SC_MR_DATA_NACK, "refused");
    rdc(DT, TXF + 8'h01, "rx kept");
    step(8'hb5, tws_pkg::SC_START, "stop then start");
    rdc(CT, 8'ha5, "stop bit cleared");
    wr(CT, 8'h95);
    repeat (1100) @(posedge clk);
    rdc(ST, tws_pkg::SC_IDLE, "after stop");
    rdc(CT, 8'h05, "stop cleared");
  endtask : t_read

  task automatic t_off;
    wr(CT, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("released", 8'h03, {6'h0, pin_oe_b});
    chk("irq", 8'h00, {7'h0, irq});
    chk("pin out", 8'h00, {6'h0, pin_out});
  endtask : t_off

  initial
  begin
    miscompares = 0;
    n_checks = 0;
    rst_b = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slv_ack = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_write();
    t_read();
    t_off();
    conclude();
  end

  // The whole sequence needs about 60k cycles; allow for margin.
  initial
  begin
    #900000;
    miscompares++;
    conclude();
  end
endmodule : tb_tws_master

// *** tb/tws_master_chk.sv ***
// Port checker for the two-wire serial master.
`timescale 1ns/10ps

module tws_master_chk
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire tws_pkg::tws_line_t pin_in,
  input wire tws_pkg::tws_line_t pin_out,
  input wire tws_pkg::tws_line_t pin_oe_b
);
  logic on_r;
  logic rdd_r;
  logic seen_r;
  logic [7:0] last_r;
  logic oe_sda_d_r;
  wire ctl_wr = reg_wr && reg_addr == 2'h0;
  wire dat_wr = reg_wr && reg_addr == 2'h2;
  wire ctl_rd = reg_rd && reg_addr == 2'h0;
  wire stop_seen = pin_oe_b.sda && !oe_sda_d_r && pin_oe_b.scl &&
                   pin_in.scl;

  // A low irq only says the flag is low once both enables are known set.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      on_r <= 1'b0;
      rdd_r <= 1'b0;
      seen_r <= 1'b0;
      last_r <= 8'h00;
      oe_sda_d_r <= 1'b1;
    end
    else
    begin
      on_r <= ctl_wr ? reg_wdata[2] && reg_wdata[0] : on_r;
      rdd_r <= reg_rd && reg_addr == 2'h2;
      seen_r <= irq && !dat_wr && (seen_r || rdd_r);
      last_r <= rdd_r ? reg_rdata : last_r;
      oe_sda_d_r <= pin_oe_b.sda;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_status_low: assert property (
    reg_rd && reg_addr == 2'h1 |=> reg_rdata[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_collision_set: assert property (
    dat_wr && on_r && !irq ##2 ctl_rd && !irq |=> reg_rdata[3])
    else $error("data write with flag low left no collision");
  a_irq_mask: assert property (
    ctl_wr && !(reg_wdata[0] && reg_wdata[2]) |-> ##2 !irq)
    else $error("irq stayed up while masked");
  a_flag_clear: assert property (
    ctl_wr && reg_wdata[7] && irq |-> ##1 !irq)
    else $error("writing one to the flag did not clear it");
  a_scl_hold: assert property (
    irq && !pin_oe_b.scl |=> !pin_oe_b.scl || !irq)
    else $error("bus clock released while flag set");
  a_stop_noflag: assert property (
    stop_seen |=> !irq [*8])
    else $error("flag raised right after a stop");
  a_disable_release: assert property (
    ctl_wr && !reg_wdata[2] |-> ##2 pin_oe_b == 2'b11)
    else $error("wires not released when disabled");
  a_data_hold: assert property (
    rdd_r && seen_r |-> reg_rdata == last_r)
    else $error("data changed while flag set");

  c_flag: cover property ($rose(irq));
  c_stop: cover property (stop_seen);
  c_collide: cover property (dat_wr && on_r && !irq);
endmodule : tws_master_chk

bind tws_master tws_master_chk chk_u (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_b(pin_oe_b));

// *** tb/tws_slave_model.sv ***
// Behavioural slave on the two-wire bus: acks addresses, sends a count.
`timescale 1ns/10ps

module tws_slave_model
#(
  parameter logic [7:0] TX_FIRST = 8'hc3
)
(
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_data,
  output logic sda_oe_b,
  output logic [7:0] rx_byte
);
  int cnt;
  logic is_addr;
  logic rd;
  logic done;
  logic [7:0] sh;
  logic [7:0] tx_q;

  initial
  begin
    sda_oe_b = 1'b1;
    cnt = 0;
    done = 1'b1;
    tx_q = TX_FIRST;
    rx_byte = 8'h00;
  end

  always @(negedge sda)
    if (scl === 1'b1)
    begin
      cnt = 0;
      is_addr = 1'b1;
      rd = 1'b0;
      done = 1'b0;
    end

  always @(posedge sda)
    if (scl === 1'b1)
      done = 1'b1;

  always @(posedge scl)
    if (cnt == 8)
    begin
      if (is_addr)
        rd = sh[0];
      else if (rd)
      begin
        done = sda;
        tx_q = tx_q + 8'h01;
      end
      else
        rx_byte = sh;
      is_addr = 1'b0;
      cnt = 0;
    end
    else
    begin
      sh = {sh[6:0], sda};
      cnt++;
    end

  // Change the data line well inside the low phase of the bus clock.
  always @(negedge scl)
  begin
    #50;
    if (done)
      sda_oe_b = 1'b1;
    else if (cnt == 8)
      sda_oe_b = !(is_addr || (!rd && ack_data));
    else
      sda_oe_b = (is_addr || !rd) ? 1'b1 : tx_q[3'(7 - cnt)];
  end
endmodule : tws_slave_model
